// *** iotmd_core.sv ***
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "iotmd_params.svh"
module iotmd_core #(
  parameter int MEM_DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] port_c_pins,
  input wire logic [3:0] port_d_pins,
  input wire logic [3:0] serial_port_value,
  output logic [3:0] port_a_latch,
  output logic [3:0] port_b_latch,
  output logic [3:0] port_c_out,
  output logic [3:0] port_c_oe_n,
  output logic [3:0] port_d_latch,
  output logic [3:0] port_e_output,
  output logic [3:0] stop_wake_edge_mask,
  output logic stop_wake,
  output logic [7:0] timer0_init_load,
  output logic timer0_start,
  output logic [7:0] timer1_init_load,
  output logic timer1_start,
  output logic [3:0] alu_output_holder,
  output logic zero_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [31:0] rd_mux;

  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & ~waitrequest_q;
  wire bus_wr = bus_take & avs_write;
  wire bus_rd_sample = avs_read & waitrequest_q;
  wire sel_instr = avs_address == `IOTMD_OFS_INSTR;
  wire sel_status = avs_address == `IOTMD_OFS_STATUS;
  wire sel_ports = avs_address == `IOTMD_OFS_PORTS;
  wire sel_timers = avs_address == `IOTMD_OFS_TIMERS;
  wire sel_mode = avs_address == `IOTMD_OFS_MODE;
  wire sel_mem_ptr = avs_address == `IOTMD_OFS_MEM_PTR;
  wire sel_mem_data = avs_address == `IOTMD_OFS_MEM_DATA;
  wire exec = bus_wr & sel_instr & (&avs_byteenable[1:0]);
  wire mode_wr = bus_wr & sel_mode & avs_byteenable[0];
  wire ptr_wr = bus_wr & sel_mem_ptr & avs_byteenable[0];

  // Each access waits one cycle, then completes; the idle level is high.
  wire waitrequest_d = ~(bus_req & waitrequest_q);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      waitrequest_q <= waitrequest_d;
      if (bus_rd_sample)
        readdata_q <= rd_mux;
    end
  end

  assign avs_waitrequest = waitrequest_q;
  assign avs_readdata = readdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields and decode.

  wire [15:0] instr = avs_writedata[15:0];
  wire [6:0] r_addr = instr[6:0];
  wire [3:0] w_slot = instr[10:7];
  wire [3:0] imm4 = instr[10:7];
  wire [7:0] imm8 = instr[7:0];
  wire [3:0] wake_imm = instr[3:0];
  wire [6:0] slot_addr = `IOTMD_WR_BASE | {3'h0, w_slot};

  iotmd_pkg::iotmd_op_type op;

  iotmd_op_decode u_dec (
    .valid(exec),
    .instr(instr),
    .op(op)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data memory.

  logic mem_we;
  logic [3:0] mem_wd;
  logic [3:0] r_data;
  logic [3:0] slot_data;
  logic [3:0] ptr_data;
  logic [6:0] mem_ptr_q;
  logic load_acc;
  logic [3:0] acc_src;

  iotmd_nibble_ram #(
    .DEPTH(MEM_DEPTH),
    .AW(7),
    .DW(4)
  ) u_ram (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(r_addr),
    .wr_data(mem_wd),
    .rd_a_addr(r_addr),
    .rd_a_data(r_data),
    .rd_b_addr(slot_addr),
    .rd_b_data(slot_data),
    .rd_c_addr(mem_ptr_q),
    .rd_c_data(ptr_data)
  );

  always_comb
  begin
    mem_we = 1'b0;
    mem_wd = 4'h0;
    load_acc = 1'b0;
    acc_src = 4'h0;
    unique case (op)
      iotmd_pkg::iotmd_op_rd_c:
      begin
        mem_we = 1'b1;
        mem_wd = port_c_pins;
        load_acc = 1'b1;
        acc_src = port_c_pins;
      end
      iotmd_pkg::iotmd_op_rd_d:
      begin
        mem_we = 1'b1;
        mem_wd = port_d_pins;
        load_acc = 1'b1;
        acc_src = port_d_pins;
      end
      iotmd_pkg::iotmd_op_mov_wr:
      begin
        mem_we = 1'b1;
        mem_wd = slot_data;
      end
      iotmd_pkg::iotmd_op_mov_imm:
      begin
        mem_we = 1'b1;
        mem_wd = imm4;
      end
      iotmd_pkg::iotmd_op_none, iotmd_pkg::iotmd_op_wr_a, iotmd_pkg::iotmd_op_wr_b,
      iotmd_pkg::iotmd_op_wr_c, iotmd_pkg::iotmd_op_wr_d, iotmd_pkg::iotmd_op_wr_e,
      iotmd_pkg::iotmd_op_wake_en, iotmd_pkg::iotmd_op_t0_imm, iotmd_pkg::iotmd_op_t0_lo,
      iotmd_pkg::iotmd_op_t0_hi, iotmd_pkg::iotmd_op_t1_imm:
      begin
        mem_we = 1'b0;
      end
      default:
      begin
        mem_we = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator, ports, timers and modes.

  logic [3:0] acc_q;
  logic zf_q;
  logic [3:0] port_a_q, port_b_q, port_c_q, port_d_q, port_e_q;
  logic [3:0] pc_dir_q, pe_mode_q, pe_pin_q;
  logic [3:0] wake_mask_q, pc_prev_q;
  logic wake_q;
  logic [7:0] t0_load_q, t1_load_q;
  logic t0_start_q, t1_start_q;

  wire op_wr_a = op == iotmd_pkg::iotmd_op_wr_a;
  wire op_wr_b = op == iotmd_pkg::iotmd_op_wr_b;
  wire op_wr_c = op == iotmd_pkg::iotmd_op_wr_c;
  wire op_wr_d = op == iotmd_pkg::iotmd_op_wr_d;
  wire op_wr_e = op == iotmd_pkg::iotmd_op_wr_e;
  wire op_wake_en = op == iotmd_pkg::iotmd_op_wake_en;
  wire op_t0_imm = op == iotmd_pkg::iotmd_op_t0_imm;
  wire op_t0_lo = op == iotmd_pkg::iotmd_op_t0_lo;
  wire op_t0_hi = op == iotmd_pkg::iotmd_op_t0_hi;
  wire op_t1_imm = op == iotmd_pkg::iotmd_op_t1_imm;

  wire [3:0] acc_d = load_acc ? acc_src : acc_q;
  wire zf_d = load_acc ? (acc_src == 4'h0) : zf_q;
  wire [7:0] t0_load_d = op_t0_imm ? imm8 :
                         op_t0_lo ? {t0_load_q[7:4], r_data} :
                         op_t0_hi ? {r_data, t0_load_q[3:0]} :
                         t0_load_q;
  wire [7:0] t1_load_d = op_t1_imm ? imm8 : t1_load_q;
  wire [3:0] pe_pin_d = pe_mode_q[`IOTMD_PE_SERIAL_BIT] ? serial_port_value : port_e_q;
  wire [3:0] pc_fall = pc_prev_q & ~port_c_pins & wake_mask_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 4'h0;
      zf_q <= 1'b0;
      t0_load_q <= 8'h00;
      t1_load_q <= 8'h00;
      t0_start_q <= 1'b0;
      t1_start_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      zf_q <= zf_d;
      t0_load_q <= t0_load_d;
      t1_load_q <= t1_load_d;
      t0_start_q <= op_t0_imm;
      t1_start_q <= op_t1_imm;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_q <= 4'h0;
      port_b_q <= 4'h0;
      port_c_q <= 4'h0;
      port_d_q <= 4'h0;
      port_e_q <= 4'h0;
    end
    else
    begin
      port_a_q <= op_wr_a ? r_data : port_a_q;
      port_b_q <= op_wr_b ? r_data : port_b_q;
      port_c_q <= op_wr_c ? r_data : port_c_q;
      port_d_q <= op_wr_d ? r_data : port_d_q;
      port_e_q <= op_wr_e ? r_data : port_e_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_dir_q <= `IOTMD_RST_PC_DIR;
      pe_mode_q <= `IOTMD_RST_PE_MODE;
      pe_pin_q <= 4'h0;
      mem_ptr_q <= 7'h00;
      wake_mask_q <= 4'h0;
      pc_prev_q <= 4'hf;
      wake_q <= 1'b0;
    end
    else
    begin
      pc_dir_q <= mode_wr ? avs_writedata[3:0] : pc_dir_q;
      pe_mode_q <= mode_wr ? avs_writedata[7:4] : pe_mode_q;
      pe_pin_q <= pe_pin_d;
      mem_ptr_q <= ptr_wr ? avs_writedata[6:0] : mem_ptr_q;
      wake_mask_q <= op_wake_en ? wake_imm : wake_mask_q;
      pc_prev_q <= port_c_pins;
      wake_q <= |pc_fall;
    end
  end

  // A pin whose direction bit is one is an input, so the driver stays off.
  assign port_c_oe_n = pc_dir_q;
  assign port_c_out = port_c_q;
  assign port_a_latch = port_a_q;
  assign port_b_latch = port_b_q;
  assign port_d_latch = port_d_q;
  assign port_e_output = pe_pin_q;
  assign stop_wake_edge_mask = wake_mask_q;
  assign stop_wake = wake_q;
  assign timer0_init_load = t0_load_q;
  assign timer0_start = t0_start_q;
  assign timer1_init_load = t1_load_q;
  assign timer1_start = t1_start_q;
  assign alu_output_holder = acc_q;
  assign zero_flag = zf_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection; unmapped offsets read as zero.

  assign rd_mux = sel_status ? {27'h0, zf_q, acc_q} :
                  sel_ports ? {4'h0, port_d_pins, port_c_pins, port_e_q, port_d_q,
                               port_c_q, port_b_q, port_a_q} :
                  sel_timers ? {12'h000, wake_mask_q, t1_load_q, t0_load_q} :
                  sel_mode ? {24'h00_0000, pe_mode_q, pc_dir_q} :
                  sel_mem_ptr ? {25'h000_0000, mem_ptr_q} :
                  sel_mem_data ? {28'h000_0000, ptr_data} :
                  32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence ack_cycle;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence one_pulse0;
    timer0_start ##1 !timer0_start;
  endsequence

  bus_answer_a: assert property (bus_req && avs_waitrequest |=> ack_cycle)
    else $error("Bus access was not answered after one wait cycle.");

  port_c_read_a: assert property (
    op == iotmd_pkg::iotmd_op_rd_c |=> alu_output_holder == $past(port_c_pins)
      && zero_flag == ($past(port_c_pins) == 4'h0))
    else $error("Port C read did not load accumulator and zero flag.");

  port_d_read_a: assert property (
    op == iotmd_pkg::iotmd_op_rd_d |=> alu_output_holder == $past(port_d_pins))
    else $error("Port D read did not load the accumulator.");

  read_mem_a: assert property (
    (op == iotmd_pkg::iotmd_op_rd_c) |-> mem_we && mem_wd == port_c_pins)
    else $error("Port C read did not write memory.");

  slot_move_a: assert property (
    op == iotmd_pkg::iotmd_op_mov_wr |-> mem_we && mem_wd == slot_data
      && slot_addr[3:0] == instr[10:7])
    else $error("Work slot move wrote the wrong nibble.");

  imm_move_a: assert property (
    op == iotmd_pkg::iotmd_op_mov_imm |-> mem_we && mem_wd == instr[10:7])
    else $error("Immediate move wrote the wrong nibble.");

  zero_hold_a: assert property (
    !load_acc |=> $stable(zero_flag) && $stable(alu_output_holder))
    else $error("Zero flag changed without a port read.");

  port_a_write_a: assert property (op_wr_a |=> port_a_latch == $past(r_data))
    else $error("Port A latch not loaded.");

  port_b_write_a: assert property (op_wr_b |=> port_b_latch == $past(r_data))
    else $error("Port B latch not loaded.");

  port_c_write_a: assert property (op_wr_c |=> port_c_out == $past(r_data))
    else $error("Port C latch not loaded.");

  port_d_write_a: assert property (op_wr_d |=> port_d_latch == $past(r_data))
    else $error("Port D latch not loaded.");

  port_e_write_a: assert property (
    op_wr_e && !pe_mode_q[`IOTMD_PE_SERIAL_BIT] && !mode_wr |=> ##1 port_e_output == $past(r_data, 2))
    else $error("Port E latch did not reach the pins.");

  wake_mask_a: assert property (op_wake_en |=> stop_wake_edge_mask == $past(instr[3:0]))
    else $error("Wake enables not loaded.");

  wake_edge_a: assert property (
    (stop_wake_edge_mask[0] && $fell(port_c_pins[0])) |=> stop_wake)
    else $error("Enabled falling edge on pin 0 did not wake.");

  timer0_load_a: assert property (
    op_t0_imm && !$past(op_t0_imm) |=> timer0_init_load == $past(instr[7:0]) and one_pulse0
      or timer0_start && timer0_init_load == $past(instr[7:0]))
    else $error("Timer 0 immediate load failed.");

  timer0_nib_a: assert property (
    op_t0_lo |=> timer0_init_load == {$past(timer0_init_load[7:4]), $past(r_data)})
    else $error("Timer 0 low nibble load failed.");

  timer0_high_a: assert property (
    op_t0_hi |=> timer0_init_load == {$past(r_data), $past(timer0_init_load[3:0])})
    else $error("Timer 0 high nibble load failed.");

  timer1_load_a: assert property (
    op_t1_imm |=> timer1_start && timer1_init_load == $past(instr[7:0]))
    else $error("Timer 1 immediate load failed.");

  dir_change_a: assert property ($changed(port_c_oe_n) |-> $past(mode_wr))
    else $error("Port C direction changed without a mode write.");

  port_e_mode_a: assert property (
    ##1 port_e_output == ($past(pe_mode_q[`IOTMD_PE_SERIAL_BIT]) ? $past(serial_port_value) : $past(port_e_q)))
    else $error("Port E output source is wrong for its mode.");
endmodule : iotmd_core

// *** iotmd_params.svh ***
`ifndef IOTMD_PARAMS_SVH
`define IOTMD_PARAMS_SVH

// Register byte offsets.
`define IOTMD_OFS_INSTR 6'h00
`define IOTMD_OFS_STATUS 6'h04
`define IOTMD_OFS_PORTS 6'h08
`define IOTMD_OFS_TIMERS 6'h0c
`define IOTMD_OFS_MODE 6'h10
`define IOTMD_OFS_MEM_PTR 6'h14
`define IOTMD_OFS_MEM_DATA 6'h18

// Opcode prefixes, matched on the upper instruction bits.
`define IOTMD_PFX_RD_C 9'h096
`define IOTMD_PFX_RD_D 9'h097
`define IOTMD_PFX_MOV_WR 4'hf
`define IOTMD_PFX_MOV_IMM 5'h17
`define IOTMD_PFX_WR_A 9'h0b4
`define IOTMD_PFX_WR_B 9'h0b5
`define IOTMD_PFX_WR_C 9'h118
`define IOTMD_PFX_WR_D 9'h119
`define IOTMD_PFX_WR_E 8'h5c
`define IOTMD_PFX_WAKE_EN 11'h290
`define IOTMD_PFX_T0_IMM 8'h10
`define IOTMD_PFX_T0_LO 9'h028
`define IOTMD_PFX_T0_HI 9'h029
`define IOTMD_PFX_T1_IMM 8'h11

// Reset values and field positions.
`define IOTMD_RST_PC_DIR 4'hf
`define IOTMD_RST_PE_MODE 4'h0
`define IOTMD_PE_SERIAL_BIT 1
`define IOTMD_WR_BASE 7'h00
`endif

// *** iotmd_pkg.sv ***
package iotmd_pkg;
  typedef enum logic [3:0] {
    iotmd_op_none = 4'h0,
    iotmd_op_rd_c = 4'h1,
    iotmd_op_rd_d = 4'h2,
    iotmd_op_mov_wr = 4'h3,
    iotmd_op_mov_imm = 4'h4,
    iotmd_op_wr_a = 4'h5,
    iotmd_op_wr_b = 4'h6,
    iotmd_op_wr_c = 4'h7,
    iotmd_op_wr_d = 4'h8,
    iotmd_op_wr_e = 4'h9,
    iotmd_op_wake_en = 4'ha,
    iotmd_op_t0_imm = 4'hb,
    iotmd_op_t0_lo = 4'hc,
    iotmd_op_t0_hi = 4'hd,
    iotmd_op_t1_imm = 4'he
  } iotmd_op_type;
endpackage : iotmd_pkg

// *** iotmd_op_decode.sv ***
`timescale 1ns/100ps
`include "iotmd_params.svh"
module iotmd_op_decode (
  input wire logic valid,
  input wire logic [15:0] instr,
  output iotmd_pkg::iotmd_op_type op
);
  wire m_rd_c = instr[15:7] == `IOTMD_PFX_RD_C;
  wire m_rd_d = instr[15:7] == `IOTMD_PFX_RD_D;
  wire m_mov_wr = instr[15:12] == `IOTMD_PFX_MOV_WR;
  wire m_mov_imm = instr[15:11] == `IOTMD_PFX_MOV_IMM;
  wire m_wr_a = instr[15:7] == `IOTMD_PFX_WR_A;
  wire m_wr_b = instr[15:7] == `IOTMD_PFX_WR_B;
  wire m_wr_c = instr[15:7] == `IOTMD_PFX_WR_C;
  wire m_wr_d = instr[15:7] == `IOTMD_PFX_WR_D;
  wire m_wr_e = instr[15:8] == `IOTMD_PFX_WR_E;
  wire m_wake_en = instr[15:5] == `IOTMD_PFX_WAKE_EN;
  wire m_t0_imm = instr[15:8] == `IOTMD_PFX_T0_IMM;
  wire m_t0_lo = instr[15:7] == `IOTMD_PFX_T0_LO;
  wire m_t0_hi = instr[15:7] == `IOTMD_PFX_T0_HI;
  wire m_t1_imm = instr[15:8] == `IOTMD_PFX_T1_IMM;

  // Prefixes never overlap, so the order of this chain carries no priority.
  assign op = !valid ? iotmd_pkg::iotmd_op_none :
              m_rd_c ? iotmd_pkg::iotmd_op_rd_c :
              m_rd_d ? iotmd_pkg::iotmd_op_rd_d :
              m_mov_wr ? iotmd_pkg::iotmd_op_mov_wr :
              m_mov_imm ? iotmd_pkg::iotmd_op_mov_imm :
              m_wr_a ? iotmd_pkg::iotmd_op_wr_a :
              m_wr_b ? iotmd_pkg::iotmd_op_wr_b :
              m_wr_c ? iotmd_pkg::iotmd_op_wr_c :
              m_wr_d ? iotmd_pkg::iotmd_op_wr_d :
              m_wr_e ? iotmd_pkg::iotmd_op_wr_e :
              m_wake_en ? iotmd_pkg::iotmd_op_wake_en :
              m_t0_imm ? iotmd_pkg::iotmd_op_t0_imm :
              m_t0_lo ? iotmd_pkg::iotmd_op_t0_lo :
              m_t0_hi ? iotmd_pkg::iotmd_op_t0_hi :
              m_t1_imm ? iotmd_pkg::iotmd_op_t1_imm :
              iotmd_pkg::iotmd_op_none;
endmodule : iotmd_op_decode

// *** iotmd_nibble_ram.sv ***
`timescale 1ns/100ps
module iotmd_nibble_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [DW-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [DW-1:0] rd_b_data,
  input wire logic [AW-1:0] rd_c_addr,
  output logic [DW-1:0] rd_c_data
);
  if (DEPTH < 16 || DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("DEPTH must hold the working slots and fit the address.");
  end

  logic [DW-1:0] mem_q [DEPTH];

  // Locations at or above DEPTH ignore writes and read as zero.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en && int'(wr_addr) < DEPTH)
      mem_q[wr_addr] <= wr_data;
  end

  assign rd_a_data = int'(rd_a_addr) < DEPTH ? mem_q[rd_a_addr] : '0;
  assign rd_b_data = int'(rd_b_addr) < DEPTH ? mem_q[rd_b_addr] : '0;
  assign rd_c_data = int'(rd_c_addr) < DEPTH ? mem_q[rd_c_addr] : '0;
endmodule : iotmd_nibble_ram

// *** iotmd_pin_model.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Port C and D pins as seen from the core.
// A port C pin follows the core's latch only while its direction bit drives it.
module iotmd_pin_model (
  input wire logic [3:0] port_c_out,
  input wire logic [3:0] port_c_oe_n,
  input wire logic [3:0] c_ext,
  input wire logic [3:0] d_ext,
  output logic [3:0] port_c_pins,
  output logic [3:0] port_d_pins
);
  assign port_c_pins = (port_c_oe_n & c_ext) | (~port_c_oe_n & port_c_out);
  assign port_d_pins = d_ext;
endmodule : iotmd_pin_model

// *** tb_io_timer_move_decode.sv ***
`timescale 1ns/100ps
module tb_io_timer_move_decode;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] c_ext = 4'h0;
  logic [3:0] d_ext = 4'h0;
  logic [3:0] ser = 4'h0;
  logic [3:0] pc, pd, pa_l, pb_l, pc_l, pc_oe_n, pd_l, pe, mask;
  logic wake, t0s, t1s, zf;
  logic [7:0] t0, t1;
  logic [3:0] acc;
  logic [31:0] q;
  logic [6:0] mad [4] = '{7'h03, 7'h05, 7'h40, 7'h7f};
  logic [3:0] rv [4] = '{4'h9, 4'h6, 4'ha, 4'hf};
  int n_fail = 0;
  int samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  iotmd_core i_iotmd_core (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_c_pins(pc), .port_d_pins(pd), .serial_port_value(ser),
    .port_a_latch(pa_l), .port_b_latch(pb_l), .port_c_out(pc_l), .port_c_oe_n(pc_oe_n), .port_d_latch(pd_l),
    .port_e_output(pe), .stop_wake_edge_mask(mask), .stop_wake(wake), .timer0_init_load(t0),
    .timer0_start(t0s), .timer1_init_load(t1), .timer1_start(t1s), .alu_output_holder(acc), .zero_flag(zf));

  iotmd_pin_model i_iotmd_pin_model (.port_c_out(pc_l), .port_c_oe_n(pc_oe_n), .c_ext(c_ext), .d_ext(d_ext),
    .port_c_pins(pc), .port_d_pins(pd));

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    chk(32'(n), 32'h2, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic ex(input logic [15:0] i);
    bus(6'h00, 1'b1, {16'h0, i});
  endtask : ex

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp, input string s);
    bus(a, 1'b0, 32'h0);
    chk(q & m, exp, s);
  endtask : rd_chk

  task automatic mem_chk(input logic [6:0] r, input logic [3:0] exp);
    bus(6'h14, 1'b1, {25'h0, r});
    rd_chk(6'h18, 32'hf, {28'h0, exp}, "memory nibble");
  endtask : mem_chk

  // Counts stop wake pulses seen over four cycles.
  task automatic wake_chk(input int exp);
    int n;
    n = 0;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1;
      if (wake !== 1'b0)
      begin
        n++;
      end
    end
    chk(32'(n), 32'(exp), "wake pulses");
  endtask : wake_chk

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(6'h10, 32'hff, 32'h0f, "mode after reset");
    chk({28'h0, pc_oe_n}, 32'hf, "direction after reset");
    rd_chk(6'h3c, 32'hffffffff, 32'h0, "unmapped read");
    $display("test reset done");
    foreach (mad[k]) ex({5'h17, rv[k], mad[k]});
    foreach (mad[k]) mem_chk(mad[k], rv[k]);
    ex({4'hf, 1'b0, 4'h3, 7'h20});
    mem_chk(7'h20, 4'h9);
    ex({4'hf, 1'b1, 4'h5, 7'h21});
    mem_chk(7'h21, 4'h6);
    $display("test memory moves done");
    ex({9'h0b4, 7'h03});
    ex({9'h0b5, 7'h05});
    ex({9'h118, 7'h40});
    ex({9'h119, 7'h7f});
    ex({8'h5c, 1'b0, 7'h03});
    rd_chk(6'h08, 32'hfffff, 32'h9fa69, "latch fields");
    chk({16'h0, pa_l, pb_l, pc_l, pd_l}, 32'h96af, "latch pins");
    chk({28'h0, pe}, 32'h9, "port e parallel");
    $display("test port writes done");
    c_ext <= 4'h5;
    d_ext <= 4'h0;
    ex({9'h096, 7'h10});
    rd_chk(6'h04, 32'h1f, 32'h05, "acc port c");
    chk({27'h0, zf, acc}, 32'h05, "accumulator pins");
    mem_chk(7'h10, 4'h5);
    ex({9'h097, 7'h11});
    rd_chk(6'h04, 32'h1f, 32'h10, "acc port d zero");
    mem_chk(7'h11, 4'h0);
    bus(6'h10, 1'b1, 32'h0e);
    ex({9'h096, 7'h12});
    rd_chk(6'h04, 32'h1f, 32'h04, "acc mixed pins");
    bus(6'h10, 1'b1, 32'h0f);
    $display("test port reads done");
    ex({11'h290, 1'b0, 4'h1});
    rd_chk(6'h0c, 32'hf0000, 32'h10000, "wake mask");
    chk({28'h0, mask}, 32'h1, "wake mask pins");
    c_ext <= 4'h1;
    wake_chk(0);
    @(posedge clk_sys);
    c_ext <= 4'h0;
    wake_chk(1);
    $display("test wake done");
    ex({8'h10, 8'ha5});
    #1;
    chk({23'h0, t0s, t0}, 32'h1a5, "timer 0 load");
    ex({9'h028, 7'h05});
    ex({9'h029, 7'h40});
    rd_chk(6'h0c, 32'hff, 32'ha6, "timer 0 nibbles");
    ser <= 4'h7;
    ex({8'h11, 8'h3c});
    #1;
    chk({23'h0, t1s, t1}, 32'h13c, "timer 1 load");
    $display("test timers done");
    bus(6'h10, 1'b1, 32'h2f);
    rd_chk(6'h10, 32'hff, 32'h2f, "mode readback");
    chk({28'h0, pe}, 32'h7, "port e serial");
    bus(6'h10, 1'b1, 32'h0f);
    rd_chk(6'h10, 32'hff, 32'h0f, "mode restore");
    chk({28'h0, pe}, 32'h9, "port e latch");
    $display("test port e mode done");
    print_verdict();
  end
endmodule : tb_io_timer_move_decode
